// >>> rtl/mbrtu_pkg.sv
// Shared constants, types and the CRC step for the drive control slave
package mbrtu_pkg;

  // ==========================================================================
  // Types
  typedef logic [7:0]  mbrtu_byte_t;
  typedef logic [15:0] mbrtu_word_t;

  typedef enum logic [1:0] {
    MBRTU_S_RX    = 2'b00,
    MBRTU_S_CHECK = 2'b01,
    MBRTU_S_TX    = 2'b10
  } mbrtu_state_t;

  // ==========================================================================
  // Function and exception codes
  localparam mbrtu_byte_t FC_READ_HOLD     = 8'h03;
  localparam mbrtu_byte_t FC_WRITE_SINGLE  = 8'h06;
  localparam mbrtu_byte_t FC_WRITE_MULTI   = 8'h10;
  localparam mbrtu_byte_t EXC_NONE         = 8'h00;
  localparam mbrtu_byte_t EXC_ILLEGAL_FUNC = 8'h01;
  localparam mbrtu_byte_t EXC_ILLEGAL_ADDR = 8'h02;
  localparam mbrtu_byte_t EXC_ILLEGAL_DATA = 8'h03;
  localparam mbrtu_byte_t EXC_FLAG         = 8'h80;
  localparam mbrtu_byte_t BROADCAST_ADDR   = 8'h00;

  // ==========================================================================
  // Frame layout (byte positions from the slave address byte)
  localparam int POS_ADDR  = 0;
  localparam int POS_FC    = 1;
  localparam int POS_START = 2;
  localparam int POS_QTY   = 4;
  localparam int POS_BCNT  = 6;
  localparam int POS_DATA  = 7;
  localparam int LEN_FIXED_REQ  = 8;
  localparam int LEN_MULTI_HDR  = 9;
  localparam int LEN_MULTI_MAX  = 17;
  localparam int LEN_MIN_FRAME  = 4;
  localparam int LEN_CRC        = 2;
  localparam int LEN_READ_HDR   = 3;
  localparam int LEN_WRITE_ECHO = 6;
  localparam int LEN_EXC_BODY   = 3;

  // ==========================================================================
  // Register map (register numbers, one above the wire address)
  localparam mbrtu_word_t REG_CTRL      = 16'h0001;
  localparam mbrtu_word_t REG_SPEED     = 16'h0002;
  localparam mbrtu_word_t REG_RAMP      = 16'h0004;
  localparam mbrtu_word_t REG_HOLD_LAST = 16'h0004;
  localparam mbrtu_word_t REG_MON_FIRST = 16'h0006;
  localparam mbrtu_word_t REG_LAST      = 16'h0018;
  localparam int          HOLD_COUNT    = 4;
  localparam int          MON_COUNT     = 19;
  localparam mbrtu_word_t HOLD_RESET    = 16'h0000;
  localparam mbrtu_word_t RAMP_MAX      = 16'hea60;

  // Control word bits
  localparam int CTRL_RUN_BIT   = 0;
  localparam int CTRL_FAST_BIT  = 1;
  localparam int CTRL_RESET_BIT = 2;
  localparam int CTRL_COAST_BIT = 3;

  localparam mbrtu_byte_t CMD_SRC_MODBUS = 8'h04;

  // ==========================================================================
  // CRC-16, reflected polynomial
  localparam mbrtu_word_t CRC_INIT = 16'hffff;
  localparam mbrtu_word_t CRC_POLY = 16'ha001;

  function automatic mbrtu_word_t crc_byte(input mbrtu_word_t crc, input mbrtu_byte_t data);
    mbrtu_word_t c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc_byte

endpackage : mbrtu_pkg

// >>> rtl/mbrtu_crc_if.sv
// Byte-wise CRC engine connection between the slave and its CRC units
`timescale 1ns/10ps
interface mbrtu_crc_if;
  logic        clear;
  logic        feed;
  logic [7:0]  data;
  logic [15:0] crc;
  logic [15:0] crc_next;

  modport engine (input clear, input feed, input data, output crc, output crc_next);
  modport user   (output clear, output feed, output data, input crc, input crc_next);
endinterface : mbrtu_crc_if

// >>> rtl/mbrtu_crc.sv
// Running CRC-16 over a byte stream
`timescale 1ns/10ps
module mbrtu_crc (
  // Clock and reset
  input  wire logic  sys_clk_in,
  input  wire logic  reset_in,
  // Engine port
  mbrtu_crc_if.engine crc_io
);
  import mbrtu_pkg::*;

  typedef struct packed {
    mbrtu_word_t crc;
  } mbrtu_crc_state_t;

  mbrtu_crc_state_t state_reg;
  mbrtu_crc_state_t state_next;

  // Next value is exported so a sender can append the low byte without a bubble
  assign crc_io.crc      = state_reg.crc;
  assign crc_io.crc_next = crc_byte(state_reg.crc, crc_io.data);

  always_comb begin
    state_next = state_reg;
    if (crc_io.clear) begin
      state_next.crc = CRC_INIT;
    end else if (crc_io.feed) begin
      state_next.crc = crc_byte(state_reg.crc, crc_io.data);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      state_reg <= '{crc: CRC_INIT};
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : mbrtu_crc

// >>> rtl/mbrtu_drive_slave.sv
// Modbus RTU slave front end for drive control, with shared channel arbitration
`timescale 1ns/10ps
//
// Operation
// R01 - Two RS-485 channels: peripheral link plus shared Modbus/CAN, concurrently usable.
// R02 - Peripheral link stays enabled whatever other interface is active.
// R03 - Shared channel runs Modbus or CAN only; Modbus selection disables CAN.
// R04 - Fitted fieldbus option module disables both Modbus and CAN.
// R05 - Slave accepts function codes 03, 06 and 16.
// R06 - Function 16 accepted only for registers 1 through 4.
// R07 - Master subtracts one from register number to form wire address.
// R08 - With Modbus active every listed register is reachable.
// R09 - Registers 1, 2 drive only with command source 4 and no option.
// R10 - Ramp register 4 applies only while fieldbus ramp control equals 1.
// R11 - Registers 6 to 24 readable regardless of command source.
// R12 - Control bit 0 set runs the drive, cleared stops it.
// R13 - Control bit 1 requests fast stop on second deceleration ramp.
// R14 - Control bit 2 requests reset of all active faults and trips.
// R15 - Master clears the reset bit after the fault has cleared.
// R16 - Control bit 3 requests a coast stop.
// R17 - Master writes speed setpoint in 0.1 Hz units.
// R18 - Ramp register accepts 0 to 60000, 0.01 s per count.
// R19 - Unsupported function or out-of-range function 16 returns an exception.
module mbrtu_drive_slave #(
  parameter int RX_MAX = mbrtu_pkg::LEN_MULTI_MAX
) (
  // Clock and reset
  input  wire logic                    sys_clk_in,
  input  wire logic                    reset_in,
  // Channel configuration
  input  wire logic                    modbus_select_in,
  input  wire logic                    fieldbus_module_present_in,
  output logic                         periph_link_enable_out,
  output logic                         modbus_enable_out,
  output logic                         can_enable_out,
  // Received bytes of the shared channel
  input  wire mbrtu_pkg::mbrtu_byte_t  rx_data_in,
  input  wire logic                    rx_valid_in,
  input  wire logic                    rx_frame_end_in,
  // Reply bytes
  output mbrtu_pkg::mbrtu_byte_t       tx_data_out,
  output logic                         tx_valid_out,
  input  wire logic                    tx_ready_in,
  // Drive settings
  input  wire mbrtu_pkg::mbrtu_byte_t  slave_addr_in,
  input  wire mbrtu_pkg::mbrtu_byte_t  command_source_select_in,
  input  wire logic                    fieldbus_ramp_enable_in,
  input  wire logic [mbrtu_pkg::MON_COUNT-1:0][15:0] monitor_regs_in,
  // Drive commands
  output logic                         run_out,
  output logic                         fast_stop_out,
  output logic                         fault_reset_out,
  output logic                         coast_stop_out,
  output mbrtu_pkg::mbrtu_word_t       speed_setpoint_out,
  output logic                         ramp_apply_out,
  output mbrtu_pkg::mbrtu_word_t       ramp_time_out
);
  import mbrtu_pkg::*;

  localparam int CNT_W = $clog2(RX_MAX + 1);
  localparam int TXI_W = 8;

  // ==========================================================================
  // Parameter check
  if (RX_MAX < LEN_MULTI_MAX) begin : g_bad_rx_max
    $error("RX_MAX too small for a four register write");
  end

  // ==========================================================================
  // State
  typedef struct packed {
    mbrtu_state_t                 st;
    logic [RX_MAX-1:0][7:0]       rx_bytes;
    logic [CNT_W-1:0]             rx_cnt;
    logic                         overflow;
    mbrtu_byte_t                  exc;
    mbrtu_byte_t                  fc;
    mbrtu_word_t                  start;
    mbrtu_word_t                  qty;
    logic [TXI_W-1:0]             tx_idx;
    logic [TXI_W-1:0]             tx_len;
    mbrtu_byte_t                  tx_data;
    logic [HOLD_COUNT-1:0][15:0]  hold;
    logic                         run;
    logic                         fast;
    logic                         freset;
    logic                         coast;
    mbrtu_word_t                  speed;
    logic                         ramp_apply;
    mbrtu_word_t                  ramp;
  } mbrtu_slave_state_t;

  mbrtu_slave_state_t state_reg;
  mbrtu_slave_state_t state_next;
  logic               modbus_active;
  logic               drive_allowed;

  mbrtu_crc_if rx_crc ();
  mbrtu_crc_if tx_crc ();

  mbrtu_crc u_rx_crc (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .crc_io(rx_crc));
  mbrtu_crc u_tx_crc (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .crc_io(tx_crc));

  // ==========================================================================
  // Channel arbitration
  assign periph_link_enable_out = 1'b1;                                // R01 R02
  assign modbus_active  = modbus_select_in && !fieldbus_module_present_in; // R03 R04
  assign modbus_enable_out = modbus_active;                            // R08
  assign can_enable_out = !modbus_select_in && !fieldbus_module_present_in; // R03 R04
  assign drive_allowed = modbus_active && !fieldbus_module_present_in &&
                         (command_source_select_in == CMD_SRC_MODBUS); // R09

  // CRC units only run in the phase they serve, cleared otherwise
  assign rx_crc.clear = (state_reg.st != MBRTU_S_RX) || (rx_frame_end_in && !modbus_active);
  assign rx_crc.feed  = (state_reg.st == MBRTU_S_RX) && rx_valid_in && modbus_active;
  assign rx_crc.data  = rx_data_in;
  assign tx_crc.clear = (state_reg.st != MBRTU_S_TX);
  assign tx_crc.feed  = (state_reg.st == MBRTU_S_TX) && tx_ready_in &&
                        (state_reg.tx_idx < state_reg.tx_len - TXI_W'(LEN_CRC));
  assign tx_crc.data  = state_reg.tx_data;

  assign tx_valid_out = (state_reg.st == MBRTU_S_TX);
  assign tx_data_out  = state_reg.tx_data;

  assign run_out            = state_reg.run;
  assign fast_stop_out      = state_reg.fast;
  assign fault_reset_out    = state_reg.freset;
  assign coast_stop_out     = state_reg.coast;
  assign speed_setpoint_out = state_reg.speed;
  assign ramp_apply_out     = state_reg.ramp_apply;
  assign ramp_time_out      = state_reg.ramp;

  // ==========================================================================
  // Register read and reply byte generation
  function automatic mbrtu_word_t read_reg(input mbrtu_word_t num, input mbrtu_slave_state_t s);
    mbrtu_word_t w;
    w = 16'h0000;
    if (num >= REG_CTRL && num <= REG_HOLD_LAST) begin
      w = s.hold[2'(num - REG_CTRL)];
    end else if (num >= REG_MON_FIRST && num <= REG_LAST) begin
      w = monitor_regs_in[5'(num - REG_MON_FIRST)];                   // R11
    end
    return w;
  endfunction : read_reg

  function automatic mbrtu_byte_t body_byte(input logic [TXI_W-1:0] idx,
                                            input mbrtu_slave_state_t s);
    mbrtu_byte_t      b;
    mbrtu_word_t      w;
    logic [TXI_W-1:0] k;
    k = idx - TXI_W'(LEN_READ_HDR);
    w = read_reg(s.start + REG_CTRL + 16'(k >> 1), s);
    if (s.exc != EXC_NONE) begin
      b = (idx == TXI_W'(POS_ADDR)) ? s.rx_bytes[POS_ADDR] :
          (idx == TXI_W'(POS_FC))   ? (s.fc | EXC_FLAG) : s.exc;      // R19
    end else if (s.fc == FC_READ_HOLD) begin
      b = (idx == TXI_W'(POS_ADDR)) ? s.rx_bytes[POS_ADDR] :
          (idx == TXI_W'(POS_FC))   ? s.fc :
          (idx == TXI_W'(POS_START)) ? s.qty[6:0] << 1 :
          (k[0] ? w[7:0] : w[15:8]);
    end else begin
      b = s.rx_bytes[idx[$clog2(RX_MAX)-1:0]];
    end
    return b;
  endfunction : body_byte

  // ==========================================================================
  // Frame handling
  always_comb begin
    mbrtu_byte_t      addr;
    mbrtu_byte_t      fc;
    mbrtu_word_t      start;
    mbrtu_word_t      qty;
    mbrtu_word_t      first;
    logic [16:0]      last_p1;
    mbrtu_word_t      word;
    mbrtu_word_t      num;
    mbrtu_byte_t      exc;
    logic             frame_ok;
    logic             len_ok;
    logic [TXI_W-1:0] nb;
    state_next = state_reg;
    word    = 16'h0000;
    num     = 16'h0000;
    addr    = state_reg.rx_bytes[POS_ADDR];
    fc      = state_reg.rx_bytes[POS_FC];
    start   = {state_reg.rx_bytes[POS_START], state_reg.rx_bytes[POS_START+1]};
    qty     = {state_reg.rx_bytes[POS_QTY], state_reg.rx_bytes[POS_QTY+1]};
    first   = start + REG_CTRL;                                        // R07
    last_p1 = {1'b0, start} + {1'b0, qty};
    exc     = EXC_NONE;
    len_ok  = 1'b0;
    nb      = state_reg.tx_idx + TXI_W'(1);
    frame_ok = !state_reg.overflow && (rx_crc.crc == 16'h0000) &&
               (state_reg.rx_cnt >= CNT_W'(LEN_MIN_FRAME)) &&
               (addr == slave_addr_in || addr == BROADCAST_ADDR);

    case (state_reg.st)
      MBRTU_S_RX: begin
        if (rx_valid_in && modbus_active) begin
          if (state_reg.rx_cnt < CNT_W'(RX_MAX)) begin
            state_next.rx_bytes[state_reg.rx_cnt] = rx_data_in;
            state_next.rx_cnt = state_reg.rx_cnt + CNT_W'(1);
          end else begin
            state_next.overflow = 1'b1;
          end
        end
        if (rx_frame_end_in) begin
          if (modbus_active && state_next.rx_cnt != '0) begin
            state_next.st = MBRTU_S_CHECK;
          end else begin
            state_next.rx_cnt   = '0;
            state_next.overflow = 1'b0;
          end
        end
      end
      MBRTU_S_CHECK: begin
        case (fc)
          FC_READ_HOLD: begin                                          // R05
            len_ok = (state_reg.rx_cnt == CNT_W'(LEN_FIXED_REQ)) && (addr != BROADCAST_ADDR);
            if (qty == 16'h0000 || qty > REG_LAST) begin
              exc = EXC_ILLEGAL_DATA;
            end else if (last_p1 > {1'b0, REG_LAST}) begin
              exc = EXC_ILLEGAL_ADDR;                                  // R08 R11
            end
          end
          FC_WRITE_SINGLE: begin                                       // R05
            len_ok = (state_reg.rx_cnt == CNT_W'(LEN_FIXED_REQ));
            if (first < REG_CTRL || first > REG_HOLD_LAST) begin
              exc = EXC_ILLEGAL_ADDR;
            end else if (first == REG_RAMP && qty > RAMP_MAX) begin
              exc = EXC_ILLEGAL_DATA;                                  // R18
            end
          end
          FC_WRITE_MULTI: begin                                        // R05
            len_ok = (state_reg.rx_cnt ==
                      CNT_W'(LEN_MULTI_HDR) + CNT_W'(state_reg.rx_bytes[POS_BCNT]));
            if (qty == 16'h0000 || qty > REG_HOLD_LAST) begin
              exc = EXC_ILLEGAL_DATA;
            end else if (last_p1 > {1'b0, REG_HOLD_LAST}) begin
              exc = EXC_ILLEGAL_ADDR;                                  // R06 R19
            end else if (state_reg.rx_bytes[POS_BCNT] != qty[6:0] << 1) begin
              exc = EXC_ILLEGAL_DATA;
            end
            for (int i = 0; i < HOLD_COUNT; i++) begin
              word = {state_reg.rx_bytes[POS_DATA+2*i], state_reg.rx_bytes[POS_DATA+2*i+1]};
              if (16'(i) < qty && first + 16'(i) == REG_RAMP && word > RAMP_MAX &&
                  exc == EXC_NONE) begin
                exc = EXC_ILLEGAL_DATA;                                // R18
              end
            end
          end
          default: begin
            len_ok = 1'b1;
            exc    = EXC_ILLEGAL_FUNC;                                 // R19
          end
        endcase
        if (frame_ok && len_ok) begin
          if (exc == EXC_NONE && fc == FC_WRITE_SINGLE) begin
            state_next.hold[2'(first - REG_CTRL)] = qty;
          end
          if (exc == EXC_NONE && fc == FC_WRITE_MULTI) begin
            for (int i = 0; i < HOLD_COUNT; i++) begin
              num  = first + 16'(i);
              word = {state_reg.rx_bytes[POS_DATA+2*i], state_reg.rx_bytes[POS_DATA+2*i+1]};
              if (16'(i) < qty) begin
                state_next.hold[2'(num - REG_CTRL)] = word;            // R06
              end
            end
          end
          state_next.exc     = exc;
          state_next.fc      = fc;
          state_next.start   = start;
          state_next.qty     = qty;
          state_next.tx_idx  = '0;
          state_next.tx_data = addr;
          state_next.tx_len  = (exc != EXC_NONE) ? TXI_W'(LEN_EXC_BODY + LEN_CRC) :
                               (fc == FC_READ_HOLD) ?
                               TXI_W'(LEN_READ_HDR + LEN_CRC) + TXI_W'(qty << 1) :
                               TXI_W'(LEN_WRITE_ECHO + LEN_CRC);
          // Broadcast writes take effect but are never answered
          state_next.st = (addr == BROADCAST_ADDR) ? MBRTU_S_RX : MBRTU_S_TX;
        end else begin
          state_next.st = MBRTU_S_RX;
        end
        state_next.rx_cnt   = '0;
        state_next.overflow = 1'b0;
      end
      MBRTU_S_TX: begin
        if (tx_ready_in) begin
          state_next.tx_idx = nb;
          if (state_reg.tx_idx == state_reg.tx_len - TXI_W'(1)) begin
            state_next.st = MBRTU_S_RX;
          end else if (nb < state_reg.tx_len - TXI_W'(LEN_CRC)) begin
            state_next.tx_data = body_byte(nb, state_reg);
          end else if (nb == state_reg.tx_len - TXI_W'(LEN_CRC)) begin
            state_next.tx_data = tx_crc.crc_next[7:0];
          end else begin
            state_next.tx_data = tx_crc.crc[15:8];
          end
        end
      end
      default: begin
        state_next.st = MBRTU_S_RX;
      end
    endcase

    // Drive commands; run bits and speed only when Modbus owns the drive, ramp gated by fieldbus ramp control alone
    state_next.run    = drive_allowed && state_reg.hold[0][CTRL_RUN_BIT];   // R09 R12
    state_next.fast   = drive_allowed && state_reg.hold[0][CTRL_FAST_BIT];  // R13
    state_next.freset = drive_allowed && state_reg.hold[0][CTRL_RESET_BIT]; // R14
    state_next.coast  = drive_allowed && state_reg.hold[0][CTRL_COAST_BIT]; // R16
    state_next.speed  = drive_allowed ? state_reg.hold[1] : 16'h0000;       // R09
    state_next.ramp_apply = fieldbus_ramp_enable_in;                        // R10
    state_next.ramp   = fieldbus_ramp_enable_in ? state_reg.hold[3] : 16'h0000; // R10
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      state_reg            <= '0;
      state_reg.st         <= MBRTU_S_RX;
      state_reg.hold       <= {HOLD_COUNT{HOLD_RESET}};
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : mbrtu_drive_slave

// >>> bench/mbrtu_monitor.sv
// Port-level checker for the drive control slave
`timescale 1ns/10ps
module mbrtu_monitor
  import mbrtu_pkg::*;
(
  // Clock and reset
  input wire logic                   sys_clk_in,
  input wire logic                   reset_in,
  // Channel and settings
  input wire logic                   modbus_select_in,
  input wire logic                   fieldbus_module_present_in,
  input wire mbrtu_pkg::mbrtu_byte_t command_source_select_in,
  input wire logic                   fieldbus_ramp_enable_in,
  input wire logic                   tx_ready_in,
  // Observed outputs
  input wire logic                   periph_link_enable_out,
  input wire logic                   modbus_enable_out,
  input wire logic                   can_enable_out,
  input wire mbrtu_pkg::mbrtu_byte_t tx_data_out,
  input wire logic                   tx_valid_out,
  input wire logic                   run_out,
  input wire logic                   fast_stop_out,
  input wire logic                   fault_reset_out,
  input wire logic                   coast_stop_out,
  input wire mbrtu_pkg::mbrtu_word_t speed_setpoint_out,
  input wire logic                   ramp_apply_out,
  input wire mbrtu_pkg::mbrtu_word_t ramp_time_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  // ==========================================================================
  // Assertions
  chk_periph_on: assert property (periph_link_enable_out)
    else $error("peripheral link disabled");
  chk_shared_excl: assert property (!(modbus_enable_out && can_enable_out)
    && modbus_enable_out == (modbus_select_in && !fieldbus_module_present_in))
    else $error("shared channel selection wrong");
  chk_option_off: assert property (fieldbus_module_present_in
    |-> !modbus_enable_out && !can_enable_out) else $error("option did not disable");
  chk_run_gate: assert property (run_out
    |-> $past(modbus_enable_out && command_source_select_in == CMD_SRC_MODBUS))
    else $error("run without command source");
  chk_cmd_gate: assert property ((fast_stop_out || coast_stop_out || fault_reset_out
    || speed_setpoint_out != 16'h0000) |-> $past(command_source_select_in) == CMD_SRC_MODBUS)
    else $error("command passed while gated");
  chk_ramp_copy: assert property (!$past(reset_in)
    |-> ramp_apply_out == $past(fieldbus_ramp_enable_in)) else $error("ramp apply wrong");
  chk_ramp_max: assert property (ramp_time_out <= RAMP_MAX)
    else $error("ramp time above limit");
  chk_tx_hold: assert property (tx_valid_out && !tx_ready_in
    |=> tx_valid_out && $stable(tx_data_out)) else $error("reply byte dropped");
  chk_reset_quiet: assert property (disable iff (1'b0) reset_in
    |=> !tx_valid_out && !run_out) else $error("outputs active after reset");
endmodule : mbrtu_monitor

// >>> bench/mbrtu_master_model.sv
// Modbus master model: sends framed requests and gathers replies
`timescale 1ns/10ps
module mbrtu_master_model
  import mbrtu_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire mbrtu_byte_t tx_data_in,
  input  wire logic        tx_valid_in,
  output mbrtu_byte_t      rx_data_out,
  output logic             rx_valid_out,
  output logic             rx_frame_end_out,
  output logic             tx_ready_out
);
  mbrtu_byte_t reply[$];
  logic        slow = 1'b0;
  logic        grab = 1'b0;

  initial begin
    rx_data_out = 8'h00;
    rx_valid_out = 1'b0;
    rx_frame_end_out = 1'b0;
    tx_ready_out = 1'b0;
  end

  function automatic mbrtu_word_t crc16(input mbrtu_word_t c, input mbrtu_byte_t d);
    c = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction : crc16

  // Whole reply including its check word folds to zero
  function automatic logic crc_ok();
    mbrtu_word_t c;
    c = 16'hffff;
    foreach (reply[i]) c = crc16(c, reply[i]);
    return c == 16'h0000;
  endfunction : crc_ok

  // Slow mode stalls every other cycle; ready byte is taken at next rise
  always @(negedge sys_clk_in) begin : rdy
    logic r;
    r = slow ? !tx_ready_out : 1'b1;
    tx_ready_out <= r;
    if (grab && tx_valid_in && r) reply.push_back(tx_data_in);
  end

  task automatic send(input logic [119:0] req, input int n);
    mbrtu_word_t c;
    mbrtu_byte_t b;
    c = 16'hffff;
    reply.delete();
    for (int i = 0; i < n + 2; i++) begin
      b = i < n ? req[8*(n-1-i) +: 8] : (i == n ? c[7:0] : c[15:8]);
      if (i < n) c = crc16(c, b);
      @(negedge sys_clk_in);
      rx_data_out <= b;
      rx_valid_out <= 1'b1;
      rx_frame_end_out <= (i == n + 1);
    end
    @(negedge sys_clk_in);
    rx_valid_out <= 1'b0;
    rx_frame_end_out <= 1'b0;
    rx_data_out <= ~b;
    grab = 1'b1;
    repeat (60) @(negedge sys_clk_in);
    grab = 1'b0;
  endtask : send
endmodule : mbrtu_master_model

// >>> bench/tb_modbus_rtu_drive_control_slave.sv
// Self-checking bench for the drive control slave
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module tb_modbus_rtu_drive_control_slave;
  import mbrtu_pkg::*;
  typedef struct { logic [119:0] req; int rn; logic [95:0] rsp; int pn; } mbrtu_row_t;
  logic sys_clk_in, reset_in, sel, opt, ramp_en, tx_valid, rx_valid, rx_end, tx_ready;
  logic run, fast, frst, coast, periph, mb_en, can_en, ramp_apply;
  mbrtu_byte_t rx_data, tx_data, src;
  mbrtu_word_t speed, ramp_time;
  logic [MON_COUNT-1:0][15:0] mon_regs;
  int failures = 0;
  int total_checks = 0;
  mbrtu_row_t rows[13] = '{
    '{120'h1106000101f4, 6, 96'h1106000101f4, 6}, '{120'h11060000000f, 6, 96'h11060000000f, 6},
    '{120'h1110000000040800050064_0000ea60, 15, 96'h111000000004, 6},
    '{120'h110300000004, 6, 96'h1103080005006400_00ea60, 11},
    '{120'h110300050001, 6, 96'h110302a000, 5}, '{120'h110300170001, 6, 96'h110302a012, 5},
    '{120'h1110000300020400010002, 11, 96'h119002, 3}, '{120'h110400000001, 6, 96'h118401, 3},
    '{120'h11060003ea61, 6, 96'h118603, 3}, '{120'h110600040001, 6, 96'h118602, 3},
    '{120'h220600010001, 6, 96'h0, 0}, '{120'h110300000000, 6, 96'h118303, 3},
    '{120'h000600020007, 6, 96'h0, 0}};

  mbrtu_drive_slave dut (.sys_clk_in, .reset_in, .modbus_select_in(sel),
    .fieldbus_module_present_in(opt), .periph_link_enable_out(periph),
    .modbus_enable_out(mb_en), .can_enable_out(can_en), .rx_data_in(rx_data),
    .rx_valid_in(rx_valid), .rx_frame_end_in(rx_end), .tx_data_out(tx_data),
    .tx_valid_out(tx_valid), .tx_ready_in(tx_ready), .slave_addr_in(8'h11),
    .command_source_select_in(src), .fieldbus_ramp_enable_in(ramp_en),
    .monitor_regs_in(mon_regs), .run_out(run), .fast_stop_out(fast), .fault_reset_out(frst),
    .coast_stop_out(coast), .speed_setpoint_out(speed), .ramp_apply_out(ramp_apply),
    .ramp_time_out(ramp_time));
  mbrtu_master_model m (.sys_clk_in, .tx_data_in(tx_data), .tx_valid_in(tx_valid),
    .rx_data_out(rx_data), .rx_valid_out(rx_valid), .rx_frame_end_out(rx_end),
    .tx_ready_out(tx_ready));

  task automatic wrap_up;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    m.send({8'h11, 8'h06, a, v}, 6);
  endtask : wr

  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  // Whole sequence needs about 1200 cycles
  initial begin
    #80000;
    failures++;
    wrap_up();
  end

  initial begin
    {reset_in, sel, opt, ramp_en, src} = {4'b1101, CMD_SRC_MODBUS};
    for (int i = 0; i < MON_COUNT; i++) mon_regs[i] = 16'ha000 + 16'(i);
    repeat (12) @(negedge sys_clk_in);
    reset_in = 1'b0;
    foreach (rows[k]) begin
      m.slow = k[0];
      m.send(rows[k].req, rows[k].rn);
      `CHK(m.reply.size(), rows[k].pn + (rows[k].pn > 0 ? 2 : 0))
      for (int i = 0; i < rows[k].pn; i++) `CHK(m.reply[i], rows[k].rsp[8*(rows[k].pn-1-i) +: 8])
      if (rows[k].pn > 0) `CHK(m.crc_ok(), 1'b1)
    end
    `CHK({run, fast, frst, coast}, 4'b1010)
    `CHK({speed, ramp_time, ramp_apply}, {16'h0064, 16'hea60, 1'b1})
    wr(16'h0000, 16'h000a);
    `CHK({run, fast, frst, coast}, 4'b0101)
    `CHK(coast, 1'b1)
    wr(16'h0000, 16'h0001);
    `CHK({run, frst}, 2'b10)
    src = 8'h03;
    repeat (3) @(negedge sys_clk_in);
    `CHK({run, speed}, 17'h0)
    {src, ramp_en} = {CMD_SRC_MODBUS, 1'b0};
    repeat (3) @(negedge sys_clk_in);
    `CHK({run, ramp_apply, ramp_time}, 18'h20000)
    opt = 1'b1;
    m.send(rows[3].req, 6);
    `CHK({m.reply.size(), mb_en, can_en, periph}, {32'd0, 3'b001})
    {opt, sel} = 2'b00;
    #1 `CHK({mb_en, can_en, periph}, 3'b011)
    @(negedge sys_clk_in);
    sel = 1'b1;
    reset_in = 1'b1;
    repeat (2) @(negedge sys_clk_in);
    reset_in = 1'b0;
    `CHK({run, speed}, 17'h0)
    m.send(120'h110300000001, 6);
    `CHK({m.reply[2], m.reply[3], m.reply[4]}, 24'h020000)
    wrap_up();
  end
endmodule : tb_modbus_rtu_drive_control_slave

bind mbrtu_drive_slave mbrtu_monitor mon (.sys_clk_in, .reset_in, .modbus_select_in,
  .fieldbus_module_present_in, .command_source_select_in, .fieldbus_ramp_enable_in,
  .tx_ready_in, .periph_link_enable_out, .modbus_enable_out, .can_enable_out, .tx_data_out,
  .tx_valid_out, .run_out, .fast_stop_out, .fault_reset_out, .coast_stop_out,
  .speed_setpoint_out, .ramp_apply_out, .ramp_time_out);
